//--- design/aaoc_pkg.sv
// constants, encodings and word layout for the alarm and output coding block
package aaoc_pkg;

    // converter result width and code weight denominator (2^14 steps)
    localparam int          CODE_W         = 14;
    localparam int          WORD_W         = 32;
    localparam int          CNT_W          = 6;

    // conversion timing on the internal clock
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          CONV_TIME_NS   = 800;
    localparam int          CONV_CYCLES    = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  CONV_CNT_LAST  = 8'(CONV_CYCLES - 1);

    // function-select value that routes the alarm onto the shared pin
    localparam logic [1:0]  PIN_FUNC_ALARM = 2'h1;

    // range select encodings
    localparam logic [3:0]  RANGE_BI_3P0   = 4'h0;
    localparam logic [3:0]  RANGE_BI_2P5   = 4'h1;
    localparam logic [3:0]  RANGE_BI_1P5   = 4'h2;
    localparam logic [3:0]  RANGE_BI_1P25  = 4'h3;
    localparam logic [3:0]  RANGE_BI_0P625 = 4'h4;
    localparam logic [3:0]  RANGE_UNI_3P0  = 4'h8;
    localparam logic [3:0]  RANGE_UNI_2P5  = 4'h9;
    localparam logic [3:0]  RANGE_UNI_1P5  = 4'hA;
    localparam logic [3:0]  RANGE_UNI_1P25 = 4'hB;

    // code weight in units of 0.1 uV (4.096 V reference)
    localparam logic [15:0] LSB_1P5_MV     = 16'h3A98;  // 1.5 mV
    localparam logic [15:0] LSB_1P25_MV    = 16'h30D4;  // 1.25 mV
    localparam logic [15:0] LSB_0P75_MV    = 16'h1D4C;  // 0.75 mV
    localparam logic [15:0] LSB_0P625_MV   = 16'h186A;  // 0.625 mV
    localparam logic [15:0] LSB_0P375_MV   = 16'h0EA6;  // 0.375 mV
    localparam logic [15:0] LSB_0P312_MV   = 16'h0C35;  // 0.312 mV

    // flag vector positions: {supply lo, supply hi, input lo, input hi}
    localparam int          ALM_IN_HI      = 0;
    localparam int          ALM_IN_LO      = 1;
    localparam int          ALM_SUP_HI     = 2;
    localparam int          ALM_SUP_LO     = 3;
    localparam int          ALM_N          = 4;

    // output word layout
    localparam int          WORD_CODE_LSB  = 18;
    localparam int          WORD_IN_LSB    = 14;
    localparam int          WORD_SUP_LSB   = 10;

    // reset values
    localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

    // conversion sequencer, gray coded along acq -> conv -> done
    typedef enum logic [1:0] {
        AAOC_ACQ  = 2'b00,
        AAOC_CONV = 2'b01,
        AAOC_DONE = 2'b11
    } aaoc_state_e;

endpackage : aaoc_pkg

//--- design/aaoc_top.sv
// alarm evaluation, result coding and serial shift frame around the converter core
`timescale 1ns/1ps
`default_nettype none

module aaoc_top
    import aaoc_pkg::*;
#(
    parameter int HYST_W = 4
) (
    // system clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // converter core
    input  wire logic [CODE_W-1:0] adc_code_i,
    input  wire logic              supply_over_i,
    input  wire logic              supply_under_i,
    // configuration
    input  wire logic [3:0]        range_sel_i,
    input  wire logic [1:0]        second_output_pin_function_i,
    input  wire logic              input_alarm_disable_i,
    input  wire logic              supply_alarm_disable_i,
    input  wire logic [CODE_W-1:0] input_high_threshold_i,
    input  wire logic [CODE_W-1:0] input_low_threshold_i,
    input  wire logic [HYST_W-1:0] hysteresis_i,
    input  wire logic              append_input_flags_i,
    input  wire logic              append_supply_flags_i,
    input  wire logic              source_sync_i,
    input  wire logic              flag_read_i,
    // status
    output logic                   busy_o,
    output logic                   eoc_o,
    output logic [CODE_W-1:0]      result_o,
    output logic [15:0]            lsb_weight_o,
    output logic [ALM_N-1:0]       alarm_active_o,
    output logic [ALM_N-1:0]       alarm_tripped_o,
    output logic [WORD_W-1:0]      rx_word_o,
    output logic                   rx_valid_o,
    // serial link
    input  wire logic              sclk_i,
    input  wire logic              convert_start_select_i,
    input  wire logic              sdi_i,
    output logic                   sdo_o,
    output logic                   out_clk_o,
    output logic                   shared_alarm_output_pin_o
);

    // code weight of the selected range
    function automatic logic [15:0] range_lsb(input logic [3:0] sel);
        logic [15:0] w;
        w = LSB_1P5_MV;
        case (sel)
            RANGE_BI_3P0:   w = LSB_1P5_MV;
            RANGE_BI_2P5:   w = LSB_1P25_MV;
            RANGE_BI_1P5:   w = LSB_0P75_MV;
            RANGE_BI_1P25:  w = LSB_0P625_MV;
            RANGE_BI_0P625: w = LSB_0P312_MV;
            RANGE_UNI_3P0:  w = LSB_0P75_MV;
            RANGE_UNI_2P5:  w = LSB_0P625_MV;
            RANGE_UNI_1P5:  w = LSB_0P375_MV;
            RANGE_UNI_1P25: w = LSB_0P312_MV;
            default:        w = LSB_1P5_MV;
        endcase
        return w;
    endfunction

    // hysteresis limits in 17 signed bits so wrap at the code ends cannot fake a match
    function automatic logic signed [16:0] widen(input logic [CODE_W-1:0] v);
        return signed'({3'b000, v});
    endfunction

    // hysteresis widened the same way so the sums never wrap
    function automatic logic signed [16:0] widen_h(input logic [HYST_W-1:0] v);
        return signed'(17'(v));
    endfunction

    // synchronisers for pins from outside the clock domain
    logic [2:0]              sel_sync;
    logic [1:0]              over_sync;
    logic [1:0]              under_sync;

    // conversion sequencer and captured result
    aaoc_state_e             state;
    logic [7:0]              conv_cnt;
    logic                    eoc;
    logic [CODE_W-1:0]       result;

    // alarm evaluation and flags
    logic                    in_hi_state;
    logic                    in_lo_state;
    logic [ALM_N-1:0]        active;
    logic [ALM_N-1:0]        tripped;
    logic [ALM_N-1:0]        next_active;
    logic signed [16:0]      code_w;
    logic signed [16:0]      hi_clr_lim;
    logic signed [16:0]      lo_clr_lim;
    logic                    next_in_hi;
    logic                    next_in_lo;

    // word offered to the link and frame bookkeeping
    logic [WORD_W-1:0]       tx_word;
    logic [WORD_W-1:0]       shreg;
    logic [CNT_W-1:0]        cap_cnt;
    logic                    launched;
    logic                    frame_rst;
    logic                    sel_rise;

    // select pin sync; sel_sync[0] feeds only sel_sync[1], sel_sync[2] is the edge history
    // resets to the idle-high level of the pin so leaving reset cannot fake a rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_sync <= 3'h7;
        end else begin
            sel_sync <= {sel_sync[1:0], convert_start_select_i};
        end
    end

    // supply comparator levels move slowly, two stages are enough
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            over_sync  <= 2'h0;
            under_sync <= 2'h0;
        end else begin
            over_sync  <= {over_sync[0], supply_over_i};
            under_sync <= {under_sync[0], supply_under_i};
        end
    end

    // rising select edge as seen on the system clock, one to two cycles late
    assign sel_rise = sel_sync[1] & ~sel_sync[2];

    // conversion sequencer on the internal clock
    // done lasts one cycle; that cycle is the only time active flags and result move
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state    <= AAOC_ACQ;
            conv_cnt <= 8'h00;
        end else begin
            case (state)
                AAOC_ACQ: begin
                    if (sel_rise) begin
                        state    <= AAOC_CONV;
                        conv_cnt <= 8'h00;
                    end
                end
                AAOC_CONV: begin
                    // select edges are not looked at here, so they are dropped
                    if (conv_cnt == CONV_CNT_LAST) begin
                        state <= AAOC_DONE;
                    end else begin
                        conv_cnt <= conv_cnt + 8'h01;
                    end
                end
                AAOC_DONE: begin
                    state <= AAOC_ACQ;
                end
                default: begin
                    state <= AAOC_ACQ;
                end
            endcase
        end
    end

    assign eoc = (state == AAOC_DONE);

    // result capture; the core already yields straight binary for every range
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            result <= CODE_RST;
        end else if (eoc) begin
            result <= adc_code_i;
        end
    end

    // input alarm limits, both against the fresh code
    // limits may dip below zero or pass the top code; signed math keeps the compare honest
    always_comb begin
        code_w     = widen(adc_code_i);
        hi_clr_lim = widen(input_high_threshold_i) - widen_h(hysteresis_i) - 17'sd1;
        lo_clr_lim = widen(input_low_threshold_i) + widen_h(hysteresis_i) + 17'sd1;
        next_in_hi = in_hi_state;
        next_in_lo = in_lo_state;
        if (!in_hi_state && code_w > widen(input_high_threshold_i)) begin
            next_in_hi = 1'b1;
        end else if (in_hi_state && code_w <= hi_clr_lim) begin
            next_in_hi = 1'b0;
        end
        if (!in_lo_state && code_w < widen(input_low_threshold_i)) begin
            next_in_lo = 1'b1;
        end else if (in_lo_state && code_w >= lo_clr_lim) begin
            next_in_lo = 1'b0;
        end
    end

    // hysteresis state follows every conversion even while disabled
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_hi_state <= 1'b0;
            in_lo_state <= 1'b0;
        end else if (eoc) begin
            in_hi_state <= next_in_hi;
            in_lo_state <= next_in_lo;
        end
    end

    // active flags rebuilt from scratch at each end of conversion
    always_comb begin
        next_active             = '0;
        next_active[ALM_IN_HI]  = next_in_hi & ~input_alarm_disable_i;
        next_active[ALM_IN_LO]  = next_in_lo & ~input_alarm_disable_i;
        next_active[ALM_SUP_HI] = over_sync[1] & ~supply_alarm_disable_i;
        next_active[ALM_SUP_LO] = under_sync[1] & ~supply_alarm_disable_i;
    end

    // flags move only on the end-of-conversion cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            active <= '0;
        end else if (eoc) begin
            active <= next_active;
        end
    end

    // tripped flags are sticky; a trigger beats a simultaneous read clear
    // so a read that lands on the update cycle never hides a fresh alarm
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tripped <= '0;
        end else begin
            tripped <= (tripped & ~{ALM_N{flag_read_i}})
                     | ({ALM_N{eoc}} & next_active);
        end
    end

    // word offered to the link; frozen while a frame is open so the link sees a quiet bus
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_word <= WORD_RST;
        end else if (sel_sync[1]) begin
            tx_word                                 <= WORD_RST;
            tx_word[WORD_CODE_LSB +: CODE_W]        <= result;
            if (append_input_flags_i) begin
                tx_word[WORD_IN_LSB +: 2]           <= active[ALM_IN_LO:ALM_IN_HI];
                tx_word[WORD_IN_LSB + 2 +: 2]       <= tripped[ALM_IN_LO:ALM_IN_HI];
            end
            if (append_supply_flags_i) begin
                tx_word[WORD_SUP_LSB +: 2]          <= active[ALM_SUP_LO:ALM_SUP_HI];
                tx_word[WORD_SUP_LSB + 2 +: 2]      <= tripped[ALM_SUP_LO:ALM_SUP_HI];
            end
        end
    end

    // conversion status, all registered
    // busy also covers the done cycle so a polling host never opens a frame mid-update
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o   <= 1'b0;
            eoc_o    <= 1'b0;
            result_o <= CODE_RST;
        end else begin
            busy_o   <= (state != AAOC_ACQ);
            eoc_o    <= eoc;
            result_o <= result;
        end
    end

    // code weight is a pure decode of the range, registered only to keep outputs on flops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lsb_weight_o <= LSB_1P5_MV;
        end else begin
            lsb_weight_o <= range_lsb(range_sel_i);
        end
    end

    // flag copies lag the internal flags by one clock, the same lag as the alarm pin
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_active_o  <= '0;
            alarm_tripped_o <= '0;
        end else begin
            alarm_active_o  <= active;
            alarm_tripped_o <= tripped;
        end
    end

    // alarm pin: any active flag, only when the pin is set to alarm duty
    // disabled alarms never reach active, so the selector is the only gate needed here
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shared_alarm_output_pin_o <= 1'b0;
        end else begin
            shared_alarm_output_pin_o <= (second_output_pin_function_i == PIN_FUNC_ALARM)
                                       & (|active);
        end
    end

    // received word handed over at frame close; sclk is idle then, so shreg is stable
    // the host must leave sclk parked until the pulse, about three system clocks
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_word_o  <= WORD_RST;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= sel_rise;
            if (sel_rise) begin
                rx_word_o <= shreg;
            end
        end
    end

    // link side: select high ends the frame and clears the bit bookkeeping
    // a frame cut short still closes cleanly; the partial word is handed over as it stands
    // source_sync_i is read on the link clock unsynchronised, so change it only between frames
    assign frame_rst = rst_i | convert_start_select_i;

    // capture edge: first edge loads the offered word behind the incoming bit
    always_ff @(posedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            cap_cnt <= '0;
        end else if (cap_cnt != CNT_W'(WORD_W)) begin
            cap_cnt <= cap_cnt + CNT_W'(1);
        end
    end

    // no reset so the word survives into the clock domain after the frame closes
    always_ff @(posedge sclk_i) begin
        if (cap_cnt == '0) begin
            shreg <= {tx_word[WORD_W-2:0], sdi_i};
        end else begin
            shreg <= {shreg[WORD_W-2:0], sdi_i};
        end
    end

    // launch edge: msb of the offered word first, then the running register
    // out_clk_o restarts low at every frame, so a full frame gives an even count of toggles
    always_ff @(negedge sclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            launched  <= 1'b0;
            sdo_o     <= 1'b0;
            out_clk_o <= 1'b0;
        end else begin
            launched  <= 1'b1;
            sdo_o     <= launched ? shreg[WORD_W-1] : tx_word[WORD_W-1];
            // device-clocked strobe toggles with each launched bit; host samples both edges
            out_clk_o <= source_sync_i ? ~out_clk_o : 1'b0;
        end
    end

endmodule : aaoc_top

`default_nettype wire

//--- verif/aaoc_host_model.sv
// host side model: frames the link and shifts one word each way
`timescale 1ns/1ps
`default_nettype none
module aaoc_host_model (
    // link towards the device
    output logic      sclk_o,
    output logic      select_o,
    output logic      sdi_o,
    input  wire logic sdo_i,
    input  wire logic out_clk_i
);
    // 125 ns link period; clock parks high between frames
    localparam realtime HALF = 62.5;
    int toggles;

    // idle levels before the first frame
    initial begin
        sclk_o = 1'b1;
        select_o = 1'b1;
        sdi_o = 1'b0;
        toggles = 0;
    end

    // count strobe edges inside a frame only
    always @(out_clk_i) if (!select_o) toggles++;

    // launch on falling, capture on rising, msb first
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        toggles = 0;
        select_o = 1'b0; // frame opens
        #(HALF);
        for (int i = 31; i >= 0; i--) begin
            sclk_o = 1'b0;
            sdi_o = tx[i];
            #(HALF);
            sclk_o = 1'b1;
            rx[i] = sdo_i;
            #(HALF);
        end
        // rising select starts the conversion
        select_o = 1'b1;
        // released data line must not look like a held bit
        sdi_o = ~sdi_o;
    endtask

    // out-of-order select blip while converting; the device must ignore it
    task automatic poke();
        select_o = 1'b0;
        #(HALF);
        select_o = 1'b1;
    endtask
endmodule // aaoc_host_model
`default_nettype wire

//--- verif/aaoc_chk.sv
// port-level assertions for the alarm and output coding block
`timescale 1ns/1ps
`default_nettype none
module aaoc_chk
    import aaoc_pkg::*;
(
    // clock, reset and controls
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic [1:0]       second_output_pin_function_i,
    input wire logic             input_alarm_disable_i,
    input wire logic             supply_alarm_disable_i,
    input wire logic             flag_read_i,
    input wire logic             convert_start_select_i,
    // observed outputs
    input wire logic             busy_o,
    input wire logic             eoc_o,
    input wire logic [ALM_N-1:0] alarm_active_o,
    input wire logic [ALM_N-1:0] alarm_tripped_o,
    input wire logic             rx_valid_o,
    input wire logic             out_clk_o,
    input wire logic             shared_alarm_output_pin_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // pin follows enabled active flags one clock later
    property p_pin;
        shared_alarm_output_pin_o == ($past(second_output_pin_function_i == PIN_FUNC_ALARM) && |alarm_active_o);
    endproperty
    a_pin: assert property (p_pin) else $error("alarm pin wrong");
    // active flags move only around an end of conversion
    property p_hold;
        $changed(alarm_active_o) |-> eoc_o || $past(eoc_o) || $past(eoc_o, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("flags moved mid conversion");
    // a tripped bit only drops after a flag read
    property p_trip_clr;
        |($past(alarm_tripped_o) & ~alarm_tripped_o) |-> $past(flag_read_i) || $past(flag_read_i, 2) || $past(flag_read_i, 3);
    endproperty
    a_trip_clr: assert property (p_trip_clr) else $error("tripped lost without read");
    // fresh active flags always show as tripped too
    property p_trip_set;
        $changed(alarm_active_o) |-> (alarm_active_o & ~alarm_tripped_o) == '0;
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("active without tripped");
    // conversion length from busy to done pulse
    property p_conv;
        $rose(busy_o) |-> ##[99:101] eoc_o;
    endproperty
    a_conv: assert property (p_conv) else $error("conversion length wrong");
    // done is a single pulse
    property p_eoc;
        eoc_o |=> !eoc_o;
    endproperty
    a_eoc: assert property (p_eoc) else $error("done pulse too long");
    // disabled alarms never raise their flags
    property p_dis;
        $changed(alarm_active_o) |-> !(input_alarm_disable_i && |alarm_active_o[1:0])
            && !(supply_alarm_disable_i && |alarm_active_o[3:2]);
    endproperty
    a_dis: assert property (p_dis) else $error("disabled alarm flagged");
    // received word announced once, after the frame closed
    property p_rxv;
        rx_valid_o |-> convert_start_select_i ##1 !rx_valid_o;
    endproperty
    a_rxv: assert property (p_rxv) else $error("receive pulse wrong");
    // strobe held low outside frames
    property p_oclk;
        convert_start_select_i && $past(convert_start_select_i) |-> !out_clk_o;
    endproperty
    a_oclk: assert property (p_oclk) else $error("strobe outside frame");

    c_alarm: cover property (eoc_o ##[1:2] |alarm_active_o);
    c_read: cover property (flag_read_i && |alarm_tripped_o);
    c_rx: cover property (rx_valid_o);
endmodule // aaoc_chk
bind aaoc_top aaoc_chk i_aaoc_chk (.clk_i, .rst_i, .second_output_pin_function_i, .input_alarm_disable_i,
    .supply_alarm_disable_i, .flag_read_i, .convert_start_select_i, .busy_o, .eoc_o, .alarm_active_o,
    .alarm_tripped_o, .rx_valid_o, .out_clk_o, .shared_alarm_output_pin_o);
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench: alarms, coding and link frames against a host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import aaoc_pkg::*;
    // design inputs with time-zero values
    logic clk_i = 1'b0, rst_i = 1'b1, supply_over_i = 1'b0, supply_under_i = 1'b0, flag_read_i = 1'b0;
    logic input_alarm_disable_i = 1'b0, supply_alarm_disable_i = 1'b0, source_sync_i = 1'b0;
    logic append_input_flags_i = 1'b1, append_supply_flags_i = 1'b1;
    logic [CODE_W-1:0] adc_code_i = '0, input_high_threshold_i = 14'h03E8, input_low_threshold_i = 14'h00C8;
    logic [3:0] range_sel_i = 4'h0, hysteresis_i = 4'h3;
    logic [1:0] second_output_pin_function_i = 2'h1;
    // design outputs and link wires
    logic busy_o, eoc_o, rx_valid_o, sdo_o, out_clk_o, shared_alarm_output_pin_o, sclk_i, convert_start_select_i, sdi_i;
    logic [CODE_W-1:0] result_o;
    logic [15:0] lsb_weight_o;
    logic [ALM_N-1:0] alarm_active_o, alarm_tripped_o;
    logic [WORD_W-1:0] rx_word_o;
    // reference state and stimulus tables
    logic [CODE_W-1:0] m_res = '0;
    logic [3:0] m_act = '0, m_trip = '0;
    logic m_hi = 1'b0, m_lo = 1'b0;
    logic [3:0] ranges [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};
    logic [CODE_W-1:0] corner [9] = '{14'h03E8, 14'h03E9, 14'h03E5, 14'h03E4, 14'h3FFF, 14'h0000, 14'h00CB,
        14'h00CC, 14'h00C7};
    int err_count = 0, checked = 0;

    aaoc_top #(.HYST_W(4)) i_aaoc_top (.clk_i, .rst_i, .adc_code_i, .supply_over_i, .supply_under_i, .range_sel_i,
        .second_output_pin_function_i, .input_alarm_disable_i, .supply_alarm_disable_i, .input_high_threshold_i,
        .input_low_threshold_i, .hysteresis_i, .append_input_flags_i, .append_supply_flags_i, .source_sync_i,
        .flag_read_i, .busy_o, .eoc_o, .result_o, .lsb_weight_o, .alarm_active_o, .alarm_tripped_o, .rx_word_o,
        .rx_valid_o, .sclk_i, .convert_start_select_i, .sdi_i, .sdo_o, .out_clk_o, .shared_alarm_output_pin_o);
    aaoc_host_model i_aaoc_host_model (.sclk_o(sclk_i), .select_o(convert_start_select_i), .sdi_o(sdi_i),
        .sdo_i(sdo_o), .out_clk_i(out_clk_o));

    // 8 ns system clock
    initial forever #4 clk_i = ~clk_i;

    // code weight per range, in 0.1 uV
    function automatic logic [15:0] lsb_of(input logic [3:0] r);
        case (r)
            4'h0: return 16'h3A98;
            4'h1: return 16'h30D4;
            4'h2, 4'h8: return 16'h1D4C;
            4'h3, 4'h9: return 16'h186A;
            4'hA: return 16'h0EA6;
            default: return 16'h0C35;
        endcase
    endfunction
    // outgoing word built from state held when the frame opens
    function automatic logic [31:0] word_of();
        return {m_res, append_input_flags_i ? {m_trip[1:0], m_act[1:0]} : 4'h0,
                append_supply_flags_i ? {m_trip[3:2], m_act[3:2]} : 4'h0, 10'h000};
    endfunction
    // inputs move 1 ns after the edge so sampling never races
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one frame, one conversion, then the flag and word checks
    // rd[0] reads the flags after the update, rd[1] on the update edge itself
    task automatic run(input logic [CODE_W-1:0] c, input logic [1:0] rd);
        logic [31:0] tx, rx;
        int n;
        tx = $urandom;
        n = 0;
        adc_code_i = c;
        tick(4);
        check(lsb_weight_o, lsb_of(range_sel_i));
        i_aaoc_host_model.frame(tx, rx);
        check(rx, word_of());
        check(i_aaoc_host_model.toggles, source_sync_i ? 32 : 0);
        // busy seen one edge after start; the blip spans eight clocks, then land on the update edge
        while (busy_o !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        i_aaoc_host_model.poke();
        tick(CONV_CYCLES - 8);
        flag_read_i = rd[1];
        tick(1);
        flag_read_i = 1'b0;
        check(eoc_o, 1'b1);
        while (eoc_o !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        check(n < 400, 1'b1);
        if (c > input_high_threshold_i) m_hi = 1'b1;
        else if (int'(c) <= int'(input_high_threshold_i) - int'(hysteresis_i) - 1) m_hi = 1'b0;
        if (c < input_low_threshold_i) m_lo = 1'b1;
        else if (int'(c) >= int'(input_low_threshold_i) + int'(hysteresis_i) + 1) m_lo = 1'b0;
        m_res = c;
        m_act = {supply_under_i, supply_over_i, m_lo, m_hi} & ~{{2{supply_alarm_disable_i}}, {2{input_alarm_disable_i}}};
        m_trip = rd[1] ? m_act : (m_trip | m_act);
        tick(3);
        check(result_o, m_res);
        check(alarm_active_o, m_act);
        check(alarm_tripped_o, m_trip);
        check(shared_alarm_output_pin_o, second_output_pin_function_i == 2'h1 && |m_act);
        check(rx_word_o, tx);
        if (rd[0]) begin
            flag_read_i = 1'b1;
            tick(1);
            flag_read_i = 1'b0;
            m_trip = '0;
            tick(3);
            check(alarm_tripped_o, m_trip);
        end
        n = 0;
        while (busy_o !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        check(n < 400, 1'b1);
    endtask

    // main sequence: boundary codes first, then random settings
    initial begin
        void'($urandom(5736));
        tick(4);
        rst_i = 1'b0;
        tick(4);
        foreach (corner[i]) run(corner[i], {i == 6, i == 4});
        $display("corner test finished");
        repeat (16) begin
            range_sel_i = ranges[$urandom_range(0, 8)];
            second_output_pin_function_i = 2'($urandom);
            supply_over_i = ($urandom_range(0, 2) == 1);
            supply_under_i = !supply_over_i && ($urandom_range(0, 1) == 1);
            input_alarm_disable_i = ($urandom_range(0, 3) == 0);
            supply_alarm_disable_i = ($urandom_range(0, 3) == 0);
            {append_input_flags_i, append_supply_flags_i, source_sync_i} = 3'($urandom);
            hysteresis_i = 4'($urandom);
            run(14'($urandom_range(0, 1300)), 2'($urandom_range(0, 3)));
        end
        $display("random test finished");
        give_verdict();
    end

    // hang guard, well beyond 25 conversions with frames
    initial begin
        #300us;
        err_count++;
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
